// ---- adc_serial_port_and_sync_test.sv ----
// self-checking bench of the serial port and sync block
`default_nettype none

module adc_serial_port_and_sync_test;
	timeunit 1ns;
	timeprecision 1ns;
	import adcsp_pkg::*;
	logic clock, sys_rst, sync_n, conv_done, conv_upcoming, clk_pin_in;
	logic sclk, cs_n, din, dout, dout_oe, gp1, gp1_oe, gp2, gp2_oe;
	logic clk_oe, filter_rst, mod_rst, cal_rst, mod_clk_en;
	logic [23:0] conv_data, rd, mreg [0:7];
	logic mready;
	int err_total, check_count, cnt;

	adcsp_top i_adcsp_top (.clock(clock), .sys_rst(sys_rst), .ce(1'b1),
		.sclk(sclk), .cs_n(cs_n), .din(din), .sync_n(sync_n),
		.conv_done(conv_done), .conv_upcoming(conv_upcoming),
		.conv_data(conv_data), .clk_pin_in(clk_pin_in), .clk_pin_out(),
		.clk_pin_oe(clk_oe), .dout(dout), .dout_oe(dout_oe),
		.gp_out_one(gp1), .gp_out_one_oe(gp1_oe), .gp_out_two(gp2),
		.gp_out_two_oe(gp2_oe), .filter_rst(filter_rst), .mod_rst(mod_rst),
		.cal_rst(cal_rst), .mod_clk_en(mod_clk_en));
	adcsp_host i_adcsp_host (.clock(clock), .dout(dout), .sclk(sclk),
		.cs_n(cs_n), .din(din));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock) if (mod_clk_en === 1'b1) cnt <= cnt + 1;

	task automatic w(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input int a, input logic [23:0] v);
		i_adcsp_host.xfer(8'(a), v, 32, a[0], rd);
		if (a == 1 || (a > 2 && a < 8)) mreg[a] = v;
	endtask
	task automatic rdc(input int a);
		logic [23:0] e;
		i_adcsp_host.xfer(8'(a) | 8'h40, 24'h000000, 32, 1'b0, rd);
		e = (a > 7) ? 24'h000000 : (a == 0) ? {22'h0, sync_n, mready} :
			(a == 2) ? conv_data : mreg[a];
		chk(rd, e);
		if (a == 2) mready = 1'b0;
	endtask
	task automatic done_pulse();
		conv_data = 24'($urandom);
		conv_done = 1'b1;
		w(1);
		conv_done = 1'b0;
		mready = sync_n;
		w(2);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#4000000;
		err_total++;
		wrap_up();
	end

	initial begin
		{conv_done, conv_upcoming, clk_pin_in, conv_data} = '0;
		{sys_rst, sync_n, mready, err_total, check_count, cnt} = '0;
		sync_n = 1'b1;
		sys_rst = 1'b1;
		for (int i = 0; i < 8; i++) mreg[i] = 24'h000000;
		void'($urandom(32'h458d));
		w(2);
		chk({dout, dout_oe, filter_rst, mod_rst, cal_rst}, 24'h17);
		sys_rst = 1'b0;
		w(5);
		chk({clk_oe, filter_rst}, 24'h2);
		cnt = 0;
		w(320);
		chk(24'(cnt >= 9 && cnt <= 11), 24'h1);
		$display("test reset done");
		// ===================================================
		for (int a = 3; a < 8; a++) wr(a, 24'($urandom));
		wr(0, 24'hFFFFFF);
		wr(1, 24'($urandom) & 24'h00000F);
		chk({gp1, gp2, gp1_oe, gp2_oe}, {mreg[1][0], mreg[1][1],
			mreg[1][2], mreg[1][3]});
		for (int a = 0; a < 10; a++) if (a != 2) rdc(a);
		chk(dout_oe, 24'h0);
		$display("test registers done");
		// ===================================================
		done_pulse();
		i_adcsp_host.xfer(8'h80, 24'h000000, 8, 1'b0, rd);
		chk(24'(rd[7:0]), 24'h000000);
		rdc(0);
		rdc(2);
		rdc(0);
		done_pulse();
		conv_upcoming = 1'b1;
		w(1);
		conv_upcoming = 1'b0;
		mready = 1'b0;
		rdc(0);
		$display("test ready done");
		// ===================================================
		done_pulse();
		sync_n = 1'b0;
		mready = 1'b0;
		w(5);
		chk({filter_rst, mod_rst, cal_rst}, 24'h7);
		i_adcsp_host.xfer(8'h80, 24'h000000, 8, 1'b0, rd);
		chk(24'(rd[7:0]), 24'h0000FF);
		rdc(0);
		rdc(4);
		sync_n = 1'b1;
		w(5);
		chk({filter_rst, mod_rst, cal_rst}, 24'h0);
		$display("test sync done");
		// ===================================================
		i_adcsp_host.xfer(8'h03, 24'($urandom), 20, 1'b0, rd);
		rdc(3);
		$display("test abort done");
		// ===================================================
		wr(1, 24'h000020);
		chk(clk_oe, 24'h0);
		cnt = 0;
		repeat (40) begin
			clk_pin_in = 1'b1;
			w(4);
			clk_pin_in = 1'b0;
			w(4);
		end
		w(6);
		chk(24'(cnt >= 9 && cnt <= 10), 24'h1);
		$display("test external clock done");
		wrap_up();
	end
endmodule // adc_serial_port_and_sync_test

`default_nettype wire

// ---- adcsp_clkgen.sv ----
// master clock source: internal oscillator or external clock divided by four
`default_nettype none

module adcsp_clkgen (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [1:0] clk_sel,
	input wire logic clk_pin_in,
	output logic clk_pin_out,
	output logic clk_pin_oe,
	output logic mod_clk_en
);
	import adcsp_pkg::*;

	logic [7:0] half_cnt;
	logic int_clk;
	logic ext_s1;
	logic ext_s2;
	logic ext_d;
	logic [1:0] ext_cnt;

	wire ext_mode = (clk_sel == CLKSEL_EXT);
	wire half_done = (half_cnt == INT_HALF_LAST);
	wire int_tick = !ext_mode && half_done && !int_clk;
	wire ext_rise = ext_s2 && !ext_d;
	wire ext_tick = ext_mode && ext_rise && (ext_cnt == EXT_DIV_LAST);
	wire [7:0] next_half_cnt = half_done ? 8'h00 : half_cnt + 8'h01;

	// ===================================================
	// internal oscillator, stopped in external mode
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			half_cnt <= 8'h00;
			int_clk <= 1'b0;
		end else if (ce && !ext_mode) begin
			half_cnt <= next_half_cnt;
			if (half_done) int_clk <= !int_clk;
		end
	end

	// ===================================================
	// external clock synchroniser and divide by four
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_d <= 1'b0;
			ext_cnt <= 2'h0;
		end else if (ce) begin
			ext_s1 <= clk_pin_in;
			ext_s2 <= ext_s1;
			ext_d <= ext_s2;
			if (ext_mode && ext_rise) ext_cnt <= ext_cnt + 2'h1; // [RQ14]
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			clk_pin_out <= 1'b0;
			clk_pin_oe <= 1'b0;
			mod_clk_en <= 1'b0;
		end else if (ce) begin
			clk_pin_out <= int_clk;
			clk_pin_oe <= (clk_sel == CLKSEL_INT_OUT); // [RQ5]
			mod_clk_en <= int_tick || ext_tick; // [RQ5] [RQ14]
		end
	end
endmodule // adcsp_clkgen

`default_nettype wire

// ---- adcsp_host.sv ----
// serial master model of the host side
`default_nettype none

module adcsp_host (
	input wire logic clock,
	input wire logic dout,
	output var logic sclk,
	output var logic cs_n,
	output var logic din
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clock);
	endtask
	// ===================================================
	// one frame: command byte then data, msb first
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
		input int nb, input bit pause, output logic [23:0] rd);
		logic [31:0] sh;
		sh = {cmd, wd};
		rd = 24'h000000;
		@(negedge clock);
		cs_n = 1'b0;
		w(4);
		for (int i = 0; i < nb; i++) begin
			sclk = 1'b0;
			din = sh[31-i];
			w(6);
			rd = {rd[22:0], dout};
			sclk = 1'b1;
			w(6);
			if (pause && i % 8 == 7) w(25);
		end
		cs_n = 1'b1;
		din = ~din; // released line shows no stale level
		w(4);
	endtask
endmodule // adcsp_host

`default_nettype wire

// ---- adcsp_pkg.sv ----
// constants and types of the converter serial port and sync block
// What this block does
// RQ1: serial input bits shift in, then land in the register the command selects.
// RQ2: accept a free-running serial clock or one sent in bursts.
// RQ3: host pulls chip-select low to select the device or frame an exchange.
// RQ4: chip-select may be tied low for three-wire use without diagnostics.
// RQ5: clock pin outputs the internal clock or takes an external one.
// RQ6: sync low holds filter, filter control, calibration control and modulator in reset.
// RQ7: sync low leaves the serial port alone but forces ready high.
// RQ8: serial output pin doubles as ready flag, going low when conversion finishes.
// RQ9: an unread result lets the ready pin return high before the next update.
// RQ10: output shift register loads from any data or control register selected.
// RQ11: while selected, the output pin takes the next bit on each serial-clock fall.
// RQ12: host may use the ready falling edge as an interrupt.
// RQ13: two analog pins can each be a general-purpose output bit set by configuration.
// RQ14: an external master clock is divided by four for the modulator.
// RQ15: input bits are sampled on the serial-clock rise while selected.
// RQ16: raising chip-select drops a partial transfer and floats the output pin.
`default_nettype none

package adcsp_pkg;
	// ===================================================
	// serial framing
	localparam int REG_BITS = 24;
	localparam int CMD_BITS = 8;
	localparam int CMD_WEN_N_BIT = 7;
	localparam int CMD_READ_BIT = 6;
	localparam int CMD_SEL_W = 6;
	localparam logic [4:0] CMD_LAST = 5'h07;
	localparam logic [4:0] DATA_LAST = 5'h17;
	// ===================================================
	// register indices and fields
	localparam int REG_COUNT = 8;
	localparam int REG_STATUS = 0;
	localparam int REG_CTRL = 1;
	localparam int REG_DATA = 2;
	localparam int STAT_READY_BIT = 0;
	localparam int STAT_SYNC_BIT = 1;
	localparam int CTRL_GP1_LVL = 0;
	localparam int CTRL_GP2_LVL = 1;
	localparam int CTRL_GP1_EN = 2;
	localparam int CTRL_GP2_EN = 3;
	localparam int CTRL_CLKSEL_LSB = 4;
	localparam logic [23:0] CTRL_RESET = 24'h000000;
	localparam logic [23:0] REG_RESET = 24'h000000;
	// ===================================================
	// clock selection codes
	localparam logic [1:0] CLKSEL_INT_OUT = 2'h0;
	localparam logic [1:0] CLKSEL_INT = 2'h1;
	localparam logic [1:0] CLKSEL_EXT = 2'h2;
	// ===================================================
	// timing
	localparam int SYS_CLK_HZ = 20000000;
	localparam int INT_CLK_HZ = 614400;
	localparam int INT_HALF_CYC = SYS_CLK_HZ / (2 * INT_CLK_HZ);
	localparam int EXT_DIV = 4;
	localparam logic [7:0] INT_HALF_LAST = 8'(INT_HALF_CYC - 1);
	localparam logic [1:0] EXT_DIV_LAST = 2'(EXT_DIV - 1);

	typedef enum logic {PH_CMD, PH_DATA} adcsp_phase_t;
endpackage

`default_nettype wire

// ---- adcsp_top.sv ----
// serial port, ready flag, sync reset and pin control of the converter
`default_nettype none

module adcsp_top (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic sync_n,
	input wire logic conv_done,
	input wire logic conv_upcoming,
	input wire logic [adcsp_pkg::REG_BITS-1:0] conv_data,
	input wire logic clk_pin_in,
	output logic clk_pin_out,
	output logic clk_pin_oe,
	output logic dout,
	output logic dout_oe,
	output logic gp_out_one,
	output logic gp_out_one_oe,
	output logic gp_out_two,
	output logic gp_out_two_oe,
	output logic filter_rst,
	output logic mod_rst,
	output logic cal_rst,
	output logic mod_clk_en
);
	import adcsp_pkg::*;

	localparam int IDX_W = $clog2(REG_COUNT);

	// ===================================================
	// pin synchronisers
	logic [1:0] sclk_q;
	logic [1:0] cs_q;
	logic [1:0] din_q;
	logic [1:0] sync_q;
	logic sclk_d;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_q <= 2'h0;
			cs_q <= 2'h3;
			din_q <= 2'h0;
			sync_q <= 2'h3;
			sclk_d <= 1'b0;
		end else if (ce) begin
			sclk_q <= {sclk_q[0], sclk};
			cs_q <= {cs_q[0], cs_n};
			din_q <= {din_q[0], din};
			sync_q <= {sync_q[0], sync_n};
			sclk_d <= sclk_q[1];
		end
	end

	wire sclk_s = sclk_q[1];
	wire sel = !cs_q[1];
	wire din_s = din_q[1];
	wire sync_s = sync_q[1];
	// either clock style works: only edges count, never the clock level
	wire rise = sclk_s && !sclk_d; // [RQ2] [RQ15]
	wire fall = !sclk_s && sclk_d; // [RQ11]

	// ===================================================
	// register decode
	logic [REG_BITS-1:0] regs [REG_COUNT];
	adcsp_phase_t phase;
	logic [4:0] bit_cnt;
	logic [REG_BITS-1:0] shift_in;
	logic [REG_BITS-1:0] out_shift;
	logic is_read;
	logic [CMD_SEL_W-1:0] sel_idx;
	logic data_ready;

	function automatic logic idx_ok(input logic [CMD_SEL_W-1:0] idx);
		return idx < CMD_SEL_W'(REG_COUNT);
	endfunction

	function automatic logic idx_writable(input logic [CMD_SEL_W-1:0] idx);
		return idx_ok(idx) && idx != CMD_SEL_W'(REG_STATUS) &&
			idx != CMD_SEL_W'(REG_DATA);
	endfunction

	wire [CMD_BITS-1:0] cmd_word = {shift_in[CMD_BITS-2:0], din_s};
	wire [CMD_SEL_W-1:0] cmd_idx = cmd_word[CMD_SEL_W-1:0];
	wire [REG_BITS-1:0] data_word = {shift_in[REG_BITS-2:0], din_s};
	wire [REG_BITS-1:0] ctrl_word = regs[REG_CTRL];
	wire [REG_BITS-1:0] status_word =
		REG_BITS'({sync_s, data_ready}) << STAT_READY_BIT;
	wire [REG_BITS-1:0] stored_word = regs[cmd_idx[IDX_W-1:0]];
	wire [REG_BITS-1:0] load_val =
		!idx_ok(cmd_idx) ? REG_RESET :
		cmd_idx == CMD_SEL_W'(REG_STATUS) ? status_word :
		cmd_idx == CMD_SEL_W'(REG_DATA) ? conv_data :
		stored_word; // [RQ10]
	wire cmd_end = sel && rise && phase == PH_CMD && bit_cnt == CMD_LAST;
	wire cmd_valid = !cmd_word[CMD_WEN_N_BIT];
	wire data_end = sel && rise && phase == PH_DATA && bit_cnt == DATA_LAST;
	wire wr_hit = data_end && !is_read && idx_writable(sel_idx);
	wire data_read = data_end && is_read &&
		sel_idx == CMD_SEL_W'(REG_DATA);

	// ===================================================
	// serial engine
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			phase <= PH_CMD;
			bit_cnt <= 5'h00;
			shift_in <= REG_RESET;
			is_read <= 1'b0;
			sel_idx <= '0;
		end else if (ce) begin
			if (!sel) begin
				phase <= PH_CMD; // [RQ16]
				bit_cnt <= 5'h00;
			end else if (rise) begin
				shift_in <= data_word; // [RQ15]
				bit_cnt <= bit_cnt + 5'h01;
				if (cmd_end) begin
					bit_cnt <= 5'h00;
					if (cmd_valid) phase <= PH_DATA;
					is_read <= cmd_word[CMD_READ_BIT];
					sel_idx <= cmd_idx;
				end else if (data_end) begin
					bit_cnt <= 5'h00;
					phase <= PH_CMD;
				end
			end
		end
	end

	// register store, written after the last data bit
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < REG_COUNT; i++) regs[i] <= REG_RESET;
			regs[REG_CTRL] <= CTRL_RESET;
		end else if (ce && wr_hit) begin
			regs[sel_idx[IDX_W-1:0]] <= data_word; // [RQ1]
		end
	end

	// output shifter: ready level outside read data
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			out_shift <= REG_RESET;
			dout <= 1'b1;
			dout_oe <= 1'b0;
		end else if (ce) begin
			dout_oe <= sel; // [RQ16]
			if (cmd_end && cmd_valid && cmd_word[CMD_READ_BIT])
				out_shift <= load_val; // [RQ10]
			else if (sel && fall && phase == PH_DATA && is_read)
				out_shift <= out_shift << 1;
			if (sel && fall) begin
				if (phase == PH_DATA && is_read)
					dout <= out_shift[REG_BITS-1]; // [RQ11]
				else
					dout <= !data_ready; // [RQ8]
			end
		end
	end

	// ===================================================
	// ready flag and sync resets
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			data_ready <= 1'b0;
			filter_rst <= 1'b1;
			mod_rst <= 1'b1;
			cal_rst <= 1'b1;
		end else if (ce) begin
			if (!sync_s)
				data_ready <= 1'b0; // [RQ7]
			else if (conv_done)
				data_ready <= 1'b1; // [RQ8]
			else if (conv_upcoming || data_read)
				data_ready <= 1'b0; // [RQ9]
			filter_rst <= !sync_s; // [RQ6]
			mod_rst <= !sync_s; // [RQ6]
			cal_rst <= !sync_s; // [RQ6]
		end
	end

	// general-purpose outputs
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			gp_out_one <= 1'b0;
			gp_out_one_oe <= 1'b0;
			gp_out_two <= 1'b0;
			gp_out_two_oe <= 1'b0;
		end else if (ce) begin
			gp_out_one <= ctrl_word[CTRL_GP1_LVL]; // [RQ13]
			gp_out_one_oe <= ctrl_word[CTRL_GP1_EN]; // [RQ13]
			gp_out_two <= ctrl_word[CTRL_GP2_LVL]; // [RQ13]
			gp_out_two_oe <= ctrl_word[CTRL_GP2_EN]; // [RQ13]
		end
	end

	adcsp_clkgen u_clkgen (
		.clock(clock),
		.sys_rst(sys_rst),
		.ce(ce),
		.clk_sel(ctrl_word[CTRL_CLKSEL_LSB +: 2]),
		.clk_pin_in(clk_pin_in),
		.clk_pin_out(clk_pin_out),
		.clk_pin_oe(clk_pin_oe),
		.mod_clk_en(mod_clk_en)
	);

	// ===================================================
	// checks
	AST_SYNC_RESETS: assert property (@(posedge clock) disable iff (sys_rst) // [RQ6]
		ce && !sync_s |=> filter_rst && mod_rst && cal_rst)
		else $error("sync low did not hold the filter resets");
	AST_SYNC_RDY: assert property (@(posedge clock) disable iff (sys_rst) // [RQ7]
		ce && !sync_s |=> !data_ready && dout_oe == $past(sel))
		else $error("sync low left ready set or disturbed the port");
	AST_RDY_SET: assert property (@(posedge clock) disable iff (sys_rst) // [RQ8]
		ce && sync_s && conv_done |=> data_ready)
		else $error("finished conversion did not set ready");
	AST_RDY_DROP: assert property (@(posedge clock) disable iff (sys_rst) // [RQ9]
		ce && sync_s && conv_upcoming && !conv_done |=> !data_ready)
		else $error("unread result kept ready before the next update");
	AST_DESELECT: assert property (@(posedge clock) disable iff (sys_rst) // [RQ16]
		ce && !sel |=> !dout_oe && phase == PH_CMD && bit_cnt == 5'h00)
		else $error("deselect did not float the output and abort");
	AST_DOUT_FALL: assert property (@(posedge clock) disable iff (sys_rst) // [RQ11]
		!(ce && sel && fall) |=> $stable(dout))
		else $error("output pin changed away from a clock fall");
	AST_WRITE: assert property (@(posedge clock) disable iff (sys_rst) // [RQ1]
		ce && data_end && !is_read && sel_idx == CMD_SEL_W'(REG_CTRL)
		|=> ctrl_word == $past(data_word) ##2 gp_out_one ==
		$past(data_word[CTRL_GP1_LVL], 3))
		else $error("control write missed the register or the pin");
	AST_LOAD: assert property (@(posedge clock) disable iff (sys_rst) // [RQ10]
		ce && cmd_end && cmd_valid && cmd_word[CMD_READ_BIT]
		|=> out_shift == $past(load_val) && phase == PH_DATA)
		else $error("read command did not load the output shifter");
endmodule // adcsp_top

`default_nettype wire
